// [include/gpbank_pkg.sv]
package gpbank_pkg;

  // Bank geometry
  localparam int unsigned NUM_PADS = 10;
  localparam int unsigned MODE_W   = 2;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;

  // Register byte offsets
  localparam logic [7:0] ADDR_MODE   = 8'h00;
  localparam logic [7:0] ADDR_OUT    = 8'h04;
  localparam logic [7:0] ADDR_IN     = 8'h08;
  localparam logic [7:0] ADDR_CTRL   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Pad index positions (pad N sits at bit N-1)
  localparam int unsigned PAD_JAM   = 1;
  localparam int unsigned PAD_TXCTL = 3;
  localparam int unsigned PAD_TXMON = 4;
  localparam int unsigned PAD_ALARM = 5;
  localparam int unsigned PAD_BUZZ  = 6;

  // Pads that own an alternate function, and open drain pads
  localparam logic [9:0] ALT_CAPABLE = 10'h07A;
  localparam logic [9:0] OPEN_DRAIN  = 10'h300;

  // Reset values of the software registers
  localparam logic [19:0] RST_MODE = 20'h00000;
  localparam logic [9:0]  RST_OUT  = 10'h300;
  localparam logic        RST_CTRL = 1'h0;

  // Reset and on/off pad drive: pads 1..8 low, open drain released
  localparam logic [9:0] RST_PAD_OUT  = 10'h000;
  localparam logic [9:0] RST_PAD_OE_N = 10'h300;

  // Field positions
  localparam int unsigned CTRL_BURST_BIT  = 0;
  localparam int unsigned STAT_MON_BIT    = 0;
  localparam int unsigned STAT_ALLOW_BIT  = 1;
  localparam int unsigned STAT_TXDIS_BIT  = 2;

  // Transmit monitor timing
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned TXMON_LEAD_MS = 300;
  localparam int unsigned TXMON_TAIL_MS = 500;
  localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
  localparam int unsigned LEAD_CYC     = TXMON_LEAD_MS * CYC_PER_MS;
  localparam int unsigned TAIL_CYC     = TXMON_TAIL_MS * CYC_PER_MS;
  localparam int unsigned CNT_W        = 25;

  // Pad behaviours; the fourth code is illegal
  typedef enum logic [1:0] {
    GPB_IN,
    GPB_OUT,
    GPB_ALT
  } gpbank_mode_t;

  // Registered pad drive
  typedef struct packed {
    logic [9:0] out;
    logic [9:0] oe_n;
  } gpbank_pads_t;

  // Pick one pad's mode field from the packed mode word
  function automatic logic [1:0] gpbank_field(input logic [19:0] word, input int unsigned idx);
    gpbank_field = word[idx*MODE_W +: MODE_W];
  endfunction

endpackage

// [core/gpbank_txmon.sv]
`timescale 1ns/100ps
module gpbank_txmon #(
  parameter int unsigned LEAD_CYC = gpbank_pkg::LEAD_CYC,
  parameter int unsigned TAIL_CYC = gpbank_pkg::TAIL_CYC
) (
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic per_burst_in,
  input  wire logic call_active_in,
  input  wire logic tx_burst_in,
  output logic      monitor_out,
  output logic      burst_gate_out
);

  // Per-call sequence states
  typedef enum logic [1:0] {
    GPB_IDLE,
    GPB_LEAD,
    GPB_ACTIVE,
    GPB_TAIL
  } gpbank_mon_t;

  gpbank_mon_t                        state_ff;     // Sequence state
  gpbank_mon_t                        nxt_state;
  logic [gpbank_pkg::CNT_W-1:0]       cnt_ff;       // Lead / tail counter
  logic [gpbank_pkg::CNT_W-1:0]       nxt_cnt;
  logic                               mon_ff;       // Monitor level
  logic                               nxt_mon;
  logic                               gate_ff;      // Bursts permitted
  logic                               nxt_gate;

  localparam logic [gpbank_pkg::CNT_W-1:0] LEAD_LAST = gpbank_pkg::CNT_W'(LEAD_CYC - 1);
  localparam logic [gpbank_pkg::CNT_W-1:0] TAIL_LAST = gpbank_pkg::CNT_W'(TAIL_CYC - 1);
  localparam logic [gpbank_pkg::CNT_W-1:0] CNT_ONE   = 25'h0000001;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_mon   = mon_ff;
    nxt_gate  = gate_ff;
    unique case (state_ff)
      GPB_IDLE: begin
        // Per-burst: monitor simply follows the bursts
        if (per_burst_in) begin
          nxt_mon  = tx_burst_in;
          nxt_gate = 1'b1;
        end else if (call_active_in) begin
          // Rise first, hold bursts off for the lead time
          nxt_state = GPB_LEAD;
          nxt_mon   = 1'b1;
          nxt_gate  = 1'b0;
          nxt_cnt   = '0;
        end else begin
          nxt_mon  = 1'b0;
          nxt_gate = 1'b0;
        end
      end
      GPB_LEAD: begin
        // Bursts blocked so none can precede the 300 ms lead
        if (cnt_ff == LEAD_LAST) begin
          nxt_state = GPB_ACTIVE;
          nxt_gate  = 1'b1;
        end else begin
          nxt_cnt = cnt_ff + CNT_ONE;
        end
      end
      GPB_ACTIVE: begin
        // Tail timing starts once the call is over and no burst runs
        if (!call_active_in && !tx_burst_in) begin
          nxt_state = GPB_TAIL;
          nxt_cnt   = '0;
        end
      end
      GPB_TAIL: begin
        if (call_active_in || tx_burst_in) begin
          // Activity resumed: the last burst is not the last yet
          nxt_state = GPB_ACTIVE;
        end else if (cnt_ff == TAIL_LAST) begin
          nxt_state = GPB_IDLE;
          nxt_mon   = 1'b0;
          nxt_gate  = 1'b0;
        end else begin
          nxt_cnt = cnt_ff + CNT_ONE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_ff <= GPB_IDLE;
      cnt_ff   <= '0;
      mon_ff   <= 1'b0;
      gate_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      mon_ff   <= nxt_mon;
      gate_ff  <= nxt_gate;
    end
  end

  assign monitor_out    = mon_ff;
  assign burst_gate_out = gate_ff;

endmodule

// [core/gpbank.sv]
`timescale 1ns/100ps
// Contract
// - Each pad is input, output or alternate
// - Input read returns sampled pad level
// - Output write drives pad, query returns it
// - Alternate pad driven by internal function
// - Alternate refused on pads without function
// - Pad two alternate outputs jamming detect
// - Pad four alternate is transmitter control input
// - Pad five alternate outputs transmit monitor
// - Pad six alternate outputs alarm
// - Pad seven alternate outputs buzzer waveform
// - Pads one-eight default input, low in reset/off
// - Pads nine-ten open drain, released by default
// - Monitor leads first burst 300 ms, tails 500 ms
module gpbank #(
  parameter int unsigned LEAD_CYC = gpbank_pkg::LEAD_CYC,
  parameter int unsigned TAIL_CYC = gpbank_pkg::TAIL_CYC
) (
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  // Module state and internal functions
  input  wire logic        on_off_in,
  input  wire logic        jamming_detect_in,
  input  wire logic        alarm_in,
  input  wire logic        buzzer_in,
  input  wire logic        call_active_in,
  input  wire logic        tx_burst_in,
  output logic             tx_allow_out,
  // Pads
  input  wire logic [9:0]  pad_in,
  output logic [9:0]       pad_out,
  output logic [9:0]       pad_oe_n_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  //   Mode: two bits a pad, field N-1 is pad N
  //   Codes: 0 input, 1 output, 2 alternate
  //   Output: one bit a pad, kept in any mode
  //   Input: synchronised levels, read only
  //   Control: bit 0 picks per-burst monitor
  //   Status: monitor, allowed, pad four low
  //   Other offsets read zero, ignore writes
  //
  // Refused mode fields keep their old code
  //   Other fields of the write still land
  //   No error bit: refusal is silent
  //
  // Pad drive
  //   Input: released
  //   Output: pushed to the stored bit
  //   Open drain: low for 0, released for 1
  //   Alternate: internal source drives
  //   Pad four alternate: sense only
  //   On/off: same levels as in reset
  //
  // Reset
  //   Pads one to eight driven low
  //   Pads nine and ten released
  //   Every pad returns to input mode
  //
  // Timing
  //   Write: register loads at the strobe edge
  //   Pads follow one edge later
  //   Read: answer stands one cycle, then zero
  //   Read right after write sees the new value
  //   Input reads lag the pad two to three cycles
  //
  // Monitor
  //   Per call: rises with the call, falls after the tail
  //   Bursts stay gated during the lead time
  //   Per burst: follows the bursts one cycle late
  //   Activity in the tail restarts the wait
  //
  // Hazards
  //   Pad inputs are asynchronous: two flops first
  //   On/off and function inputs share the clock
  //   Both strobes at once: both are served
  //
  // Limitations
  //   Contention at the pads is not detected
  //   Monitor tail uses its shortest delay

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  // Software registers
  logic [19:0]              mode_ff;      // Two bits per pad
  logic [19:0]              nxt_mode;
  logic [9:0]               out_ff;       // Last written output values
  logic [9:0]               nxt_out;
  logic                     ctrl_ff;      // Monitor follows each burst
  logic                     nxt_ctrl;
  logic [31:0]              rdata_ff;     // Read answer, one cycle late
  logic [31:0]              nxt_rdata;

  // Pad sampling
  logic [9:0]               sync1_ff;     // First synchroniser stage
  logic [9:0]               sync2_ff;     // Stable pad levels

  // Pad drive and transmit permission
  gpbank_pkg::gpbank_pads_t pads_ff;      // Registered pad drive
  gpbank_pkg::gpbank_pads_t nxt_pads;
  logic                     allow_ff;     // Transmitter permitted
  logic                     nxt_allow;

  // Monitor links and pad sources
  logic                     monitor;      // Transmit activity monitor
  logic                     burst_gate;   // Lead time elapsed
  logic [9:0]               alt_src;      // Alternate function levels
  logic                     tx_disabled;  // Pad four pulled low

  ////////////////////////////////////////////////////////////////////////////
  // Pad input synchroniser; only the second stage is read
  // Pads move at any time; one flop alone could pass a
  // half-settled level on to the read path
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pad_in;
      sync2_ff <= sync1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit activity monitor
  // Bursts wait out the lead time, so in per-call mode the monitor
  // leads the first burst of a call; it runs in every pad
  // mode so the status word can show it
  gpbank_txmon #(
    .LEAD_CYC (LEAD_CYC),
    .TAIL_CYC (TAIL_CYC)
  ) u_txmon (
    .ref_clk_in     (ref_clk_in),
    .sys_rst_in     (sys_rst_in),
    .per_burst_in   (ctrl_ff),
    .call_active_in (call_active_in),
    .tx_burst_in    (tx_burst_in),
    .monitor_out    (monitor),
    .burst_gate_out (burst_gate)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Alternate function sources, one per capable pad except pad four
  // Pads without a function keep a constant low source
  // Pad four never appears here; it only senses
  always_comb begin
    alt_src                        = '0;
    alt_src[gpbank_pkg::PAD_JAM]   = jamming_detect_in;
    alt_src[gpbank_pkg::PAD_TXMON] = monitor;
    alt_src[gpbank_pkg::PAD_ALARM] = alarm_in;
    alt_src[gpbank_pkg::PAD_BUZZ]  = buzzer_in;
  end

  // Pad four as control input: low from the application stops transmission
  // As a plain input or output, pad four has no say in transmission
  assign tx_disabled =
    (gpbank_pkg::gpbank_field(mode_ff, gpbank_pkg::PAD_TXCTL) == gpbank_pkg::GPB_ALT)
    && !sync2_ff[gpbank_pkg::PAD_TXCTL];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and read answers
  always_comb begin
    logic [1:0] req;
    req       = '0;
    nxt_mode  = mode_ff;
    nxt_out   = out_ff;
    nxt_ctrl  = ctrl_ff;
    nxt_rdata = '0;

    // Writes land at the strobe edge
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        gpbank_pkg::ADDR_MODE: begin
          // Each field taken only if legal for that pad
          // Field i belongs to pad i+1
          for (int unsigned i = 0; i < gpbank_pkg::NUM_PADS; i++) begin
            req = reg_wdata_in[i*gpbank_pkg::MODE_W +: gpbank_pkg::MODE_W];
            if (req == gpbank_pkg::GPB_IN || req == gpbank_pkg::GPB_OUT) begin
              nxt_mode[i*gpbank_pkg::MODE_W +: gpbank_pkg::MODE_W] = req;
            end else if (req == gpbank_pkg::GPB_ALT && gpbank_pkg::ALT_CAPABLE[i]) begin
              nxt_mode[i*gpbank_pkg::MODE_W +: gpbank_pkg::MODE_W] = req;
            end
          end
        end
        gpbank_pkg::ADDR_OUT: begin
          // Stored in any mode, driven only in output mode
          nxt_out = reg_wdata_in[9:0];
        end
        gpbank_pkg::ADDR_CTRL: begin
          // Seen by the monitor only while it is idle
          nxt_ctrl = reg_wdata_in[gpbank_pkg::CTRL_BURST_BIT];
        end
        default: begin
          // Input and status words are read only; others unmapped
        end
      endcase
    end

    // Answer registered, shown for one cycle
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        gpbank_pkg::ADDR_MODE: begin
          // Refused codes never land, so none read back
          nxt_rdata[19:0] = mode_ff;
        end
        gpbank_pkg::ADDR_OUT: begin
          nxt_rdata[9:0] = out_ff;
        end
        gpbank_pkg::ADDR_IN: begin
          // Levels are two cycles old due to synchronising
          nxt_rdata[9:0] = sync2_ff;
        end
        gpbank_pkg::ADDR_CTRL: begin
          nxt_rdata[gpbank_pkg::CTRL_BURST_BIT] = ctrl_ff;
        end
        gpbank_pkg::ADDR_STATUS: begin
          // Live levels; a read clears nothing
          nxt_rdata[gpbank_pkg::STAT_MON_BIT]   = monitor;
          nxt_rdata[gpbank_pkg::STAT_ALLOW_BIT] = allow_ff;
          nxt_rdata[gpbank_pkg::STAT_TXDIS_BIT] = tx_disabled;
        end
        default: begin
          // Unmapped reads answer zero
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive per mode
  // Every pad is registered, so decode glitches never reach a pin
  always_comb begin
    logic [1:0] md;
    md        = '0;
    nxt_pads  = '0;
    // Permission needs the lead gate and no hold-off on pad four
    nxt_allow = !tx_disabled && burst_gate;

    for (int unsigned i = 0; i < gpbank_pkg::NUM_PADS; i++) begin
      md = gpbank_pkg::gpbank_field(mode_ff, i);
      if (on_off_in) begin
        // Switching on or off: same levels as under reset
        nxt_pads.out[i]  = gpbank_pkg::RST_PAD_OUT[i];
        nxt_pads.oe_n[i] = gpbank_pkg::RST_PAD_OE_N[i];
      end else if (md == gpbank_pkg::GPB_OUT) begin
        if (gpbank_pkg::OPEN_DRAIN[i]) begin
          // Open drain: pull low for zero, release for one
          nxt_pads.out[i]  = 1'b0;
          nxt_pads.oe_n[i] = out_ff[i];
        end else begin
          // Push-pull drive
          nxt_pads.out[i]  = out_ff[i];
          nxt_pads.oe_n[i] = 1'b0;
        end
      end else if (md == gpbank_pkg::GPB_ALT && i != gpbank_pkg::PAD_TXCTL) begin
        // Internal function owns the pad; output register ignored
        nxt_pads.out[i]  = alt_src[i];
        nxt_pads.oe_n[i] = 1'b0;
      end else begin
        // Input, or pad four sensing the application
        // The stored output bit is kept, not driven
        nxt_pads.out[i]  = 1'b0;
        nxt_pads.oe_n[i] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // Reset levels equal the on/off levels of the pads
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_ff      <= gpbank_pkg::RST_MODE;
      out_ff       <= gpbank_pkg::RST_OUT;
      ctrl_ff      <= gpbank_pkg::RST_CTRL;
      // No stale read answer after reset
      rdata_ff     <= '0;
      pads_ff.out  <= gpbank_pkg::RST_PAD_OUT;
      pads_ff.oe_n <= gpbank_pkg::RST_PAD_OE_N;
      allow_ff     <= 1'b0;
    end else begin
      mode_ff  <= nxt_mode;
      out_ff   <= nxt_out;
      ctrl_ff  <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      pads_ff  <= nxt_pads;
      allow_ff <= nxt_allow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  // No gate stands between these flops and the ports
  assign reg_rdata_out = rdata_ff;
  assign pad_out       = pads_ff.out;
  assign pad_oe_n_out  = pads_ff.oe_n;
  assign tx_allow_out  = allow_ff;

endmodule

// [tb/gpbank_app.sv]
`timescale 1ns/100ps
// Application circuitry standing at the pads
module gpbank_app (
  input  wire logic [9:0] drive_in,
  input  wire logic [9:0] oe_n_in,
  input  wire logic [9:0] ext_en_in,
  input  wire logic [9:0] ext_val_in,
  output logic      [9:0] level_out
);
  // Pull-ups on pad four and open drain pads, pull-downs on the rest
  localparam logic [9:0] PULL = 10'h308;
  // Module drive wins; contention is not modelled, though the bench's random external drive can meet it
  assign level_out = (~oe_n_in & drive_in)
                   | (oe_n_in & ((ext_en_in & ext_val_in) | (~ext_en_in & PULL)));
endmodule

// [tb/gpbank_checker.sv]
`timescale 1ns/100ps
module gpbank_checker #(
  parameter int unsigned LEAD_CYC = 8,
  parameter int unsigned TAIL_CYC = 12
) (
  input wire logic        ref_clk_in,
  input wire logic        sys_rst_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        on_off_in,
  input wire logic        jamming_detect_in,
  input wire logic        alarm_in,
  input wire logic        buzzer_in,
  input wire logic        call_active_in,
  input wire logic        tx_burst_in,
  input wire logic        tx_allow_out,
  input wire logic [9:0]  pad_in,
  input wire logic [9:0]  pad_out,
  input wire logic [9:0]  pad_oe_n_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////////////////////////////
  logic [19:0] mode_ff;   // Shadow of accepted pad modes
  logic [19:0] nxt_mode;
  logic        burst_ff;  // Shadow of per-burst monitor select
  logic        nxt_burst;
  logic [9:0]  in_mask;   // Pads currently in input mode
  // Shadow follows writes, refusing illegal mode fields
  always_comb begin
    nxt_mode = mode_ff;
    nxt_burst = burst_ff;
    for (int i = 0; i < 10; i++) begin
      in_mask[i] = (mode_ff[2*i+:2] == 2'h0);
      if (reg_wr_in && reg_addr_in == gpbank_pkg::ADDR_MODE && reg_wdata_in[2*i+:2] != 2'h3
          && (reg_wdata_in[2*i+:2] != 2'h2 || gpbank_pkg::ALT_CAPABLE[i])) begin
        nxt_mode[2*i+:2] = reg_wdata_in[2*i+:2];
      end
    end
    if (reg_wr_in && reg_addr_in == gpbank_pkg::ADDR_CTRL) begin
      nxt_burst = reg_wdata_in[0];
    end
  end
  // Register the shadow
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_ff <= 20'h00000;
      burst_ff <= 1'h0;
    end else begin
      mode_ff <= nxt_mode;
      burst_ff <= nxt_burst;
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_call_start;
    !call_active_in ##1 call_active_in;
  endsequence
  property p_rst_pads;
    $fell(sys_rst_in) |-> pad_out == 10'h000 && pad_oe_n_out == 10'h300;
  endproperty
  property p_onoff;
    on_off_in |=> pad_out == 10'h000 && pad_oe_n_out == 10'h300;
  endproperty
  property p_od_high;
    (~pad_oe_n_out[9:8] & pad_out[9:8]) == 2'h0;
  endproperty
  property p_in_rel;
    !on_off_in && !sys_rst_in |=> (pad_oe_n_out & $past(in_mask)) == $past(in_mask);
  endproperty
  property p_alt_jam;
    mode_ff[3:2] == 2'h2 && !on_off_in |=>
      !pad_oe_n_out[1] && pad_out[1] == $past(jamming_detect_in);
  endproperty
  property p_alt_alarm;
    mode_ff[11:10] == 2'h2 && !on_off_in |=> !pad_oe_n_out[5] && pad_out[5] == $past(alarm_in);
  endproperty
  property p_alt_buzz;
    mode_ff[13:12] == 2'h2 && !on_off_in |=> !pad_oe_n_out[6] && pad_out[6] == $past(buzzer_in);
  endproperty
  property p_txdis;
    (mode_ff[7:6] == 2'h2 && !pad_in[3])[*3] |=> !tx_allow_out;
  endproperty
  property p_lead;
    s_call_start ##0 (!burst_ff && !tx_allow_out) |=> !tx_allow_out [*6];
  endproperty
  a_rst_pads: assert property (p_rst_pads) else $error("pads not at reset level");
  a_onoff: assert property (p_onoff) else $error("pads wrong in on/off");
  a_od_high: assert property (p_od_high) else $error("open drain driven high");
  a_in_rel: assert property (p_in_rel) else $error("input pad driven");
  a_alt_jam: assert property (p_alt_jam) else $error("jam pad wrong");
  a_alt_alarm: assert property (p_alt_alarm) else $error("alarm pad wrong");
  a_alt_buzz: assert property (p_alt_buzz) else $error("buzzer pad wrong");
  a_txdis: assert property (p_txdis) else $error("transmit not blocked");
  a_lead: assert property (p_lead) else $error("lead time too short");
endmodule
bind gpbank gpbank_checker #(.LEAD_CYC(LEAD_CYC), .TAIL_CYC(TAIL_CYC)) u_chk (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .on_off_in(on_off_in), .jamming_detect_in(jamming_detect_in),
  .alarm_in(alarm_in), .buzzer_in(buzzer_in), .call_active_in(call_active_in),
  .tx_burst_in(tx_burst_in), .tx_allow_out(tx_allow_out), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe_n_out(pad_oe_n_out));

// [tb/gpbank_tb.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module gpbank_tb;
  localparam int unsigned LEAD = 8;  // Short lead and tail keep the run brief
  localparam int unsigned TAIL = 12;
  localparam logic [9:0]  PULL = 10'h308;
  logic        clk, rst, wr, rd, on_off, jam, alarm, buzz, call, burst, allow;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, seed;
  logic [9:0]  lvl, pout, poe_n, ext_en, ext_val, src;
  logic [19:0] mode_m;  // Expected accepted modes
  logic [9:0]  out_m;   // Expected output register
  logic [2:0]  hist;    // Burst history for the follow check
  gpbank_pkg::gpbank_pads_t ep;
  int          err_total, tests_run;
  gpbank #(.LEAD_CYC(LEAD), .TAIL_CYC(TAIL)) uut (
    .ref_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .on_off_in(on_off),
    .jamming_detect_in(jam), .alarm_in(alarm), .buzzer_in(buzz), .call_active_in(call),
    .tx_burst_in(burst), .tx_allow_out(allow), .pad_in(lvl), .pad_out(pout),
    .pad_oe_n_out(poe_n));
  gpbank_app app (.drive_in(pout), .oe_n_in(poe_n), .ext_en_in(ext_en),
    .ext_val_in(ext_val), .level_out(lvl));
  ////////////////////////////////////////////////////////////////
  // Free running clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Mode fields that the block must accept
  function automatic logic [19:0] nmode(input logic [19:0] old, input logic [19:0] w);
    nmode = old;
    for (int i = 0; i < 10; i++)
      if (w[2*i+:2] != 2'h3 && (w[2*i+:2] != 2'h2 || gpbank_pkg::ALT_CAPABLE[i]))
        nmode[2*i+:2] = w[2*i+:2];
  endfunction
  // Expected pad drive; monitor source idle, pad four input only
  function automatic gpbank_pkg::gpbank_pads_t epads(input logic [19:0] m,
      input logic [9:0] o, input logic [9:0] s);
    epads = '{out: 10'h000, oe_n: 10'h3FF};
    for (int i = 0; i < 10; i++) begin
      if (m[2*i+:2] == 2'h1 && gpbank_pkg::OPEN_DRAIN[i]) begin
        epads.oe_n[i] = o[i];
      end else if (m[2*i+:2] == 2'h1 || (m[2*i+:2] == 2'h2 && i != 3)) begin
        epads.oe_n[i] = 1'b0;
        epads.out[i] = (m[2*i+:2] == 2'h1) ? o[i] : s[i];
      end
    end
  endfunction
  ////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read and compare; data stands one cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task automatic summarize;
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog cuts a hang short
  initial begin
    #400000;
    err_total++;
    summarize;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {rst, wr, rd, on_off, jam, alarm, buzz, call, burst} = 9'h1FF & 9'h100;
    {addr, wdata, ext_en, ext_val} = '0;
    seed = 32'hD54A;
    mode_m = 20'h00000;
    out_m = 10'h300;
    repeat (15) @(posedge clk);
    #1 `CHK(pout, 10'h000)
    `CHK(poe_n, 10'h300)
    @(posedge clk) rst <= 1'b0;
    rchk(gpbank_pkg::ADDR_MODE, 32'h0);
    rchk(gpbank_pkg::ADDR_OUT, 32'h300);
    rchk(8'h40, 32'h0);
    // Random modes, outputs, sources and external drive
    repeat (30) begin
      seed = lfsr(seed);
      wr_reg(gpbank_pkg::ADDR_MODE, {12'h0, seed[19:0]});
      mode_m = nmode(mode_m, seed[19:0]);
      seed = lfsr(seed);
      out_m = seed[9:0];
      wr_reg(gpbank_pkg::ADDR_OUT, {22'h0, out_m});
      seed = lfsr(seed);
      src = seed[9:0] & 10'h062;
      jam <= src[1];
      alarm <= src[5];
      buzz <= src[6];
      ext_en <= seed[19:10];
      ext_val <= seed[29:20];
      repeat (3) @(posedge clk);
      #1 ep = epads(mode_m, out_m, src);
      `CHK(poe_n, ep.oe_n)
      `CHK(pout & ~ep.oe_n, ep.out & ~ep.oe_n)
      rchk(gpbank_pkg::ADDR_MODE, {12'h0, mode_m});
      rchk(gpbank_pkg::ADDR_OUT, {22'h0, out_m});
      rchk(gpbank_pkg::ADDR_IN, {22'h0, (~ep.oe_n & ep.out)
        | (ep.oe_n & ((ext_en & ext_val) | (~ext_en & PULL)))});
    end
    // On/off state overrides every mode
    @(posedge clk) on_off <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK(pout, 10'h000)
    `CHK(poe_n, 10'h300)
    @(posedge clk) on_off <= 1'b0;
    ext_en <= 10'h000;
    // Pads four and five in their alternate functions, per-call monitor
    wr_reg(gpbank_pkg::ADDR_MODE, 32'h280);
    wr_reg(gpbank_pkg::ADDR_CTRL, 32'h0);
    @(posedge clk) call <= 1'b1;
    repeat (3) @(posedge clk);
    #1 `CHK(pout[4], 1'b1)
    `CHK(allow, 1'b0)
    repeat (LEAD + 2) @(posedge clk);
    #1 `CHK(allow, 1'b1)
    @(posedge clk) ext_en <= 10'h008;
    ext_val <= 10'h000;
    repeat (4) @(posedge clk);
    #1 `CHK(allow, 1'b0)
    rchk(gpbank_pkg::ADDR_STATUS, 32'h5);
    @(posedge clk) ext_en <= 10'h000;
    call <= 1'b0;
    repeat (TAIL - 2) @(posedge clk);
    #1 `CHK(pout[4], 1'b1)
    repeat (8) @(posedge clk);
    #1 `CHK(pout[4], 1'b0)
    // Per-burst monitor follows random bursts
    wr_reg(gpbank_pkg::ADDR_CTRL, 32'h1);
    rchk(gpbank_pkg::ADDR_CTRL, 32'h1);
    hist = 3'h0;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      hist = {hist[1:0], burst};
      seed = lfsr(seed);
      burst <= seed[0];
      #1 if (i > 2) `CHK(pout[4], hist[1])
    end
    summarize;
  end
endmodule
